// ===== hbc_pkg.sv
package hbc_pkg;
   // Device register offsets on the host port (6-bit)
   localparam logic [5:0] A_CMD   = 6'h00;
   localparam logic [5:0] A_STAT  = 6'h01;
   localparam logic [5:0] A_MODE  = 6'h02;
   localparam logic [5:0] A_PTR   = 6'h06;
   localparam logic [5:0] A_DLO   = 6'h08;
   localparam logic [5:0] A_DHI   = 6'h09;
   localparam logic [5:0] A_RXM   = 6'h0C;
   // Field positions
   localparam int CMD_SEND  = 0;
   localparam int MODE_TXM  = 0;
   localparam int MODE_RTO  = 1;
   localparam int MODE_WORD_MODE_BIT = 2;
   localparam int STAT_IDLE = 0;
   localparam int STAT_TERR = 1;
   localparam int STAT_PERR = 2;
   localparam logic [2:0] MODE_RST = 3'h0;
   // Packet header bytes
   localparam int HDR_SID = 0;
   localparam int HDR_DID = 1;
   localparam int HDR_CP  = 2;
   localparam logic [7:0] CP_MIN = 8'h03;
   // Controller APB map
   localparam logic [7:0] P_CFG   = 8'h00;
   localparam logic [7:0] P_CMD   = 8'h04;
   localparam logic [7:0] P_WDATA = 8'h08;
   localparam logic [7:0] P_STAT  = 8'h0C;
   localparam int CFG_STYLE = 0;
   localparam int CFG_MUX   = 1;
   localparam int CFG_ALEP  = 2;
   localparam int CFG_DSINV = 3;
   localparam int CFG_WIDE  = 4;
   localparam logic [4:0] CFG_RST = 5'h00;
   localparam int CMD_WR  = 8;
   localparam int CMD_BLO = 9;
   localparam int CMD_BHI = 10;
   // Pin cycle timing in pclk cycles
   localparam logic [3:0] ALE_CYC = 4'h3;
   localparam logic [3:0] STB_CYC = 4'h6;
   localparam logic [3:0] REC_CYC = 4'h3;
endpackage : hbc_pkg

// ===== hbc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hbc_if;
   logic        bus_style_select;
   logic        addr_mux_select;
   logic        latch_enable_polarity;
   logic        strobe_polarity_select;
   logic        wide_bus_pin;
   logic [5:0]  addr_pins;
   logic        wr_or_dir;
   logic        rd_or_ds;
   logic [15:0] host_dout;
   logic        host_doe;
   logic [15:0] dev_dout;
   logic        dev_doe;
   logic [15:0] data_bus;
   assign data_bus = dev_doe ? dev_dout : (host_doe ? host_dout : 16'h0000);
   modport dev (input bus_style_select, addr_mux_select, latch_enable_polarity, strobe_polarity_select,
                input wide_bus_pin, addr_pins, wr_or_dir, rd_or_ds, data_bus,
                output dev_dout, dev_doe);
   modport hst (output bus_style_select, addr_mux_select, latch_enable_polarity, strobe_polarity_select,
                output wide_bus_pin, addr_pins, wr_or_dir, rd_or_ds, host_dout, host_doe,
                input data_bus);
endinterface : hbc_if
`default_nettype wire

// ===== hbc_host.sv
`timescale 1ns/1ps
`default_nettype none
module hbc_host
   import hbc_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Device port
   hbc_if.hst               hp
);
   typedef enum logic [2:0] {H_IDLE, H_ALE, H_SET, H_STB, H_REC} hst_state_t;

   hst_state_t  st_q;
   logic [4:0]  cfg_q;
   logic [10:0] cmd_q;
   logic [15:0] wdat_q;
   logic [15:0] rdat_q;
   logic [3:0]  cnt_q;
   logic [5:0]  adr_q;
   logic        a_q;
   logic        b_q;
   logic [15:0] dout_q;
   logic        doe_q;
   logic        rdy_q;
   logic [31:0] prd_q;
   logic        wr_acc;
   logic        busy;
   logic        ds_on;

   assign wr_acc = psel & penable & rdy_q;
   assign busy   = (st_q != H_IDLE);
   assign ds_on  = cmd_q[CMD_BLO] | cmd_q[CMD_BHI];

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, zero wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdy_q <= 1'b0;
         prd_q <= 32'h0000_0000;
      end else if (ce) begin
         rdy_q <= psel & ~penable;
         if (psel & ~penable) begin
            unique case (paddr)
               P_CFG:   prd_q <= {27'h0, cfg_q};
               P_CMD:   prd_q <= {21'h0, cmd_q};
               P_WDATA: prd_q <= {16'h0, wdat_q};
               P_STAT:  prd_q <= {rdat_q, 15'h0, busy};
               default: prd_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q  <= CFG_RST;
         wdat_q <= 16'h0000;
      end else if (ce && wr_acc && pwrite && !busy) begin
         if (paddr == P_CFG) cfg_q <= pwdata[4:0];
         if (paddr == P_WDATA) wdat_q <= pwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin cycle sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q   <= H_IDLE;
         cmd_q  <= 11'h000;
         cnt_q  <= 4'h0;
         adr_q  <= 6'h00;
         a_q    <= 1'b1;
         b_q    <= 1'b1;
         dout_q <= 16'h0000;
         doe_q  <= 1'b0;
         rdat_q <= 16'h0000;
      end else if (ce) begin
         unique case (st_q)
            H_IDLE: begin
               a_q   <= 1'b1;
               if (wr_acc && pwrite && paddr == P_CFG) b_q <= pwdata[CFG_STYLE] ? ~pwdata[CFG_DSINV] : 1'b1;
               else b_q <= cfg_q[CFG_STYLE] ? ~cfg_q[CFG_DSINV] : 1'b1;
               doe_q <= 1'b0;
               if (cfg_q[CFG_MUX]) adr_q <= 6'h00;
               else adr_q <= {2'b00, cfg_q[CFG_ALEP], ~cfg_q[CFG_ALEP], 2'b00};
               if (wr_acc && pwrite && paddr == P_CMD) begin
                  cmd_q <= pwdata[10:0];
                  cnt_q <= ALE_CYC;
                  if (cfg_q[CFG_MUX]) begin
                     adr_q <= pwdata[5:0];
                     st_q  <= H_SET;
                  end else begin
                     adr_q  <= {2'b00, cfg_q[CFG_ALEP], cfg_q[CFG_ALEP], 2'b00};
                     dout_q <= {10'h000, pwdata[5:0]};
                     doe_q  <= 1'b1;
                     st_q   <= H_ALE;
                  end
               end
            end
            H_ALE: begin
               cnt_q <= cnt_q - 4'h1;
               if (cnt_q == 4'h1) begin
                  adr_q[2] <= ~cfg_q[CFG_ALEP];
                  st_q     <= H_SET;
               end
            end
            H_SET: begin
               doe_q  <= cmd_q[CMD_WR];
               dout_q <= cfg_q[CFG_WIDE] ? wdat_q : {8'h00, wdat_q[7:0]};
               a_q    <= cfg_q[CFG_STYLE] ? ~cmd_q[CMD_WR] : 1'b1;
               cnt_q  <= STB_CYC;
               st_q   <= H_STB;
            end
            H_STB: begin
               if (cfg_q[CFG_STYLE]) begin
                  b_q <= ds_on ? cfg_q[CFG_DSINV] : ~cfg_q[CFG_DSINV];
               end else begin
                  a_q <= ~cmd_q[CMD_WR];
                  b_q <= cmd_q[CMD_WR];
               end
               cnt_q <= cnt_q - 4'h1;
               if (cnt_q == 4'h1) begin
                  if (!cmd_q[CMD_WR]) begin
                     rdat_q <= cfg_q[CFG_WIDE] ? hp.data_bus : {8'h00, hp.data_bus[7:0]};
                  end
                  a_q   <= cfg_q[CFG_STYLE] ? ~cmd_q[CMD_WR] : 1'b1;
                  b_q   <= cfg_q[CFG_STYLE] ? ~cfg_q[CFG_DSINV] : 1'b1;
                  cnt_q <= REC_CYC;
                  st_q  <= H_REC;
               end
            end
            H_REC: begin
               cnt_q <= cnt_q - 4'h1;
               if (cnt_q == 4'h1) st_q <= H_IDLE;
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   assign prdata                    = prd_q;
   assign pready                    = rdy_q;
   assign pslverr                   = 1'b0;
   assign hp.bus_style_select       = cfg_q[CFG_STYLE];
   assign hp.addr_mux_select        = cfg_q[CFG_MUX];
   assign hp.latch_enable_polarity  = cfg_q[CFG_ALEP];
   assign hp.strobe_polarity_select = cfg_q[CFG_DSINV];
   assign hp.wide_bus_pin           = cfg_q[CFG_WIDE];
   assign hp.addr_pins              = adr_q;
   assign hp.wr_or_dir              = a_q;
   assign hp.rd_or_ds               = b_q;
   assign hp.host_dout              = dout_q;
   assign hp.host_doe               = doe_q;
endmodule : hbc_host
`default_nettype wire

// ===== hbc_device.sv
// Function
// - Style pin low: strobes; high: direction plus strobe
// - Multiplexed: low data pins carry address first
// - Strobe polarity follows its select pin
// - Wide host uses low-byte strobe; narrow, 8 bits
// - Word-strobe host ORs both data strobes
// - Odd pointer word read: upper byte invalid (here: pointer bit 0 ignored, aligned word read)
// - Host-controlled peripheral only, no standalone
// - One send mode bit; per-page receive bits
// - Receiver page mode matches sender mode
// - Send starts only on own token
// - Free format: host prepares, commands, services
// - Free format: any data, host command starts
// - Remote buffer: header first, then every token
// - Remote data valid as whole bytes/words
// - Single-shot resets 0; set: one per command
// - Single-shot set stops after current packet
// - Header: source, destination, pointer bytes 0-2
// - Word bytes stay together in one packet
// - Pointer equals page size minus length
// - Bad pointer: both errors, token passed on
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module hbc_device
   import hbc_pkg::*;
#(
   parameter int PAGE_BYTES = 32
)(
   // Clock, reset, enable
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   // Host port
   hbc_if.dev                hp,
   // Token engine side
   input  wire logic         token_here,
   input  wire logic         link_ready,
   output logic      [7:0]   tx_data,
   output logic              tx_valid,
   output logic              tx_last,
   output logic              token_pass,
   output logic              send_mode_bit,
   output logic      [31:1]  page_receive_mode_bits
);
   localparam int PW = $clog2(PAGE_BYTES);
   localparam logic [8:0] CP_MAX = 9'(PAGE_BYTES - 1);

   if (PAGE_BYTES != 32 && PAGE_BYTES != 64 && PAGE_BYTES != 128 && PAGE_BYTES != 256) begin : g_bad
      $error("PAGE_BYTES must be 32, 64, 128 or 256");
   end

   typedef enum logic {S_IDLE, S_SEND} snd_state_t;

   function automatic logic is_rxm(input logic [5:0] a);
      is_rxm = (a[5:2] == A_RXM[5:2]);
   endfunction : is_rxm

   logic [7:0]    mem [PAGE_BYTES];
   logic          a1_q, a2_q, b1_q, b2_q, acc_q;
   logic [5:0]    lat_q;
   logic [2:0]    mode_q;
   logic [31:0]   rxm_q;
   logic [PW-1:0] ptr_q;
   logic [7:0]    wst_q;
   logic [7:0]    rst_q;
   logic [15:0]   dout_q;
   logic          doe_q;
   snd_state_t    st_q;
   logic          pend_q, terr_q, perr_q;
   logic [PW-1:0] idx_q;
   logic [7:0]    txd_q;
   logic          txv_q, txl_q, tp_q;
   logic          wr_act, rd_act, start, wr_stb, rd_stb, wide, wmode;
   logic          raw_wr, raw_rd;
   logic          mux, dat_hit, byte_acc, word_done;
   logic [5:0]    adr;
   logic [15:0]   din;
   logic [PW-1:0] wa;
   logic [7:0]    cp;
   logic          cp_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Strobe synchronisers and access decode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a1_q  <= 1'b0;
         a2_q  <= 1'b0;
         b1_q  <= 1'b0;
         b2_q  <= 1'b0;
         acc_q <= 1'b0;
      end else if (ce) begin
         a1_q  <= raw_wr;
         a2_q  <= a1_q;
         b1_q  <= raw_rd;
         b2_q  <= b1_q;
         acc_q <= wr_act | rd_act;
      end
   end

   // Decode before synchronising, so style and polarity changes cannot fake a strobe
   always_comb begin
      if (hp.bus_style_select) begin
         raw_wr = (hp.rd_or_ds == hp.strobe_polarity_select) & ~hp.wr_or_dir;
         raw_rd = (hp.rd_or_ds == hp.strobe_polarity_select) & hp.wr_or_dir;
      end else begin
         raw_wr = ~hp.wr_or_dir;
         raw_rd = ~hp.rd_or_ds;
      end
   end

   assign wr_act = a2_q;
   assign rd_act = b2_q;

   assign start  = (wr_act | rd_act) & ~acc_q;
   assign wr_stb = start & wr_act;
   assign rd_stb = start & rd_act;
   assign mux    = ~hp.addr_mux_select;
   assign wide   = hp.wide_bus_pin;
   assign wmode  = wide | mode_q[MODE_WORD_MODE_BIT];
   assign din    = wide ? hp.data_bus : {8'h00, hp.data_bus[7:0]};
   assign adr    = mux ? lat_q : hp.addr_pins;
   assign wa     = {ptr_q[PW-1:1], 1'b0};
   assign dat_hit   = (adr == A_DLO) | (adr == A_DHI);
   assign byte_acc  = dat_hit & ~wmode;
   assign word_done = (wide & adr == A_DLO) | (~wide & wmode & adr == A_DHI);

   ////////////////////////////////////////////////////////////////////////////
   // Address latch: follows the shared pins while enable is active
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lat_q <= 6'h00;
      end else if (ce && mux && hp.addr_pins[2] == hp.addr_pins[3]) begin
         lat_q <= hp.data_bus[5:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers and buffer pointer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= MODE_RST;
         rxm_q  <= 32'h0000_0000;
         ptr_q  <= '0;
         wst_q  <= 8'h00;
         rst_q  <= 8'h00;
      end else if (ce) begin
         if (wr_stb && adr == A_MODE) mode_q <= din[2:0];
         if (wr_stb && is_rxm(adr)) begin
            rxm_q[8*adr[1:0] +: 8] <= din[7:0];
            rxm_q[0] <= 1'b0;
         end
         if (wr_stb && adr == A_PTR) ptr_q <= din[PW-1:0];
         else if (start && byte_acc) ptr_q <= ptr_q + 1'b1;
         else if (start && word_done) ptr_q <= wa + PW'(2);
         if (wr_stb && ~wide && wmode && adr == A_DLO) wst_q <= din[7:0];
         if (rd_stb && ~wide && wmode && adr == A_DLO) rst_q <= mem[wa + 1'b1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Page buffer
   always_ff @(posedge pclk) begin
      if (ce && wr_stb && byte_acc) mem[ptr_q] <= din[7:0];
      if (ce && wr_stb && word_done) begin
         mem[wa]        <= wide ? din[7:0] : wst_q;
         mem[wa + 1'b1] <= wide ? din[15:8] : din[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data drive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dout_q <= 16'h0000;
         doe_q  <= 1'b0;
      end else if (ce) begin
         doe_q <= rd_act;
         if (rd_stb) begin
            dout_q <= 16'h0000;
            if (adr == A_STAT) dout_q <= {13'h0, perr_q, terr_q, ~pend_q & (st_q == S_IDLE)};
            if (adr == A_MODE) dout_q <= {13'h0, mode_q};
            if (adr == A_PTR) dout_q <= 16'(ptr_q);
            if (is_rxm(adr)) dout_q <= {8'h00, rxm_q[8*adr[1:0] +: 8]};
            if (byte_acc) dout_q <= {8'h00, mem[ptr_q]};
            if (wmode && adr == A_DLO) dout_q <= {wide ? mem[wa + 1'b1] : 8'h00, mem[wa]};
            if (~wide && wmode && adr == A_DHI) dout_q <= {8'h00, rst_q};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Send control
   assign cp    = mem[HDR_CP];
   assign cp_ok = (cp >= CP_MIN) && ({1'b0, cp} <= CP_MAX);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q   <= S_IDLE;
         pend_q <= 1'b0;
         terr_q <= 1'b0;
         perr_q <= 1'b0;
         idx_q  <= '0;
         txd_q  <= 8'h00;
         txv_q  <= 1'b0;
         txl_q  <= 1'b0;
         tp_q   <= 1'b0;
      end else if (ce) begin
         tp_q <= 1'b0;
         if (wr_stb && adr == A_CMD && din[CMD_SEND]) begin
            terr_q <= 1'b0;
            perr_q <= 1'b0;
         end
         unique case (st_q)
            S_IDLE: begin
               if (token_here) begin
                  if (!pend_q) begin
                     tp_q <= 1'b1;
                  end else if (!cp_ok) begin
                     terr_q <= 1'b1;
                     perr_q <= 1'b1;
                     pend_q <= mode_q[MODE_TXM] & ~mode_q[MODE_RTO];
                     tp_q   <= 1'b1;
                  end else begin
                     txd_q <= mem[cp[PW-1:0]];
                     txv_q <= 1'b1;
                     txl_q <= ({1'b0, cp} == CP_MAX);
                     idx_q <= cp[PW-1:0] + 1'b1;
                     st_q  <= S_SEND;
                  end
               end
            end
            S_SEND: begin
               if (link_ready) begin
                  if (txl_q) begin
                     txv_q  <= 1'b0;
                     txl_q  <= 1'b0;
                     tp_q   <= 1'b1;
                     pend_q <= mode_q[MODE_TXM] & ~mode_q[MODE_RTO];
                     st_q   <= S_IDLE;
                  end else begin
                     txd_q <= mem[idx_q];
                     txl_q <= (idx_q == CP_MAX[PW-1:0]);
                     idx_q <= idx_q + 1'b1;
                  end
               end
            end
         endcase
         if (wr_stb && adr == A_CMD && din[CMD_SEND]) pend_q <= 1'b1;
      end
   end

   assign tx_data                = txd_q;
   assign tx_valid               = txv_q;
   assign tx_last                = txl_q;
   assign token_pass             = tp_q;
   assign send_mode_bit          = mode_q[MODE_TXM];
   assign page_receive_mode_bits = rxm_q[31:1];
   assign hp.dev_dout            = dout_q;
   assign hp.dev_doe             = doe_q;
endmodule : hbc_device
`default_nettype wire

// ===== hbc_props.sv
`timescale 1ns/1ps
`default_nettype none
module hbc_props (
   // Clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // Pin port
   input wire logic       bus_style_select,
   input wire logic       strobe_polarity_select,
   input wire logic       wr_or_dir,
   input wire logic       rd_or_ds,
   input wire logic       host_doe,
   input wire logic       dev_doe,
   // Token side
   input wire logic       token_here,
   input wire logic       link_ready,
   input wire logic [7:0] tx_data,
   input wire logic       tx_valid,
   input wire logic       tx_last,
   input wire logic       token_pass
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd_act;
   assign rd_act = bus_style_select ? (wr_or_dir && rd_or_ds == strobe_polarity_select) : !rd_or_ds;
   ////////////////////////////////////////////////////////////////////////
   one_driver_a: assert property (!(dev_doe && host_doe))
      else $error("Data bus driven from both ends");
   strobe_excl_a: assert property (!bus_style_select && $stable(bus_style_select) |-> wr_or_dir || rd_or_ds)
      else $error("Read and write strobes active together");
   read_answer_a: assert property ($rose(rd_act) && $stable(bus_style_select) && $stable(strobe_polarity_select)
      |-> ##[1:6] dev_doe) else $error("No read data after read strobe");
   read_only_a: assert property ($rose(dev_doe) |-> rd_act)
      else $error("Device drives data without read strobe");
   read_release_a: assert property ($fell(rd_act) |-> ##[1:5] !dev_doe)
      else $error("Device keeps driving after strobe end");
   tx_on_token_a: assert property ($rose(tx_valid) |-> $past(token_here))
      else $error("Send started without own token");
   tx_hold_a: assert property (tx_valid && !link_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
      else $error("Send byte changed before acceptance");
   last_pass_a: assert property (tx_valid && tx_last && link_ready |=> !tx_valid ##[0:1] token_pass)
      else $error("Token not passed after last byte");
   pass_pulse_a: assert property (token_pass |=> !token_pass)
      else $error("Token pass longer than one cycle");
   pass_idle_a: assert property (token_pass |-> !tx_valid)
      else $error("Token passed while sending");
endmodule : hbc_props
`default_nettype wire

// ===== host_bus_and_comm_mode_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_and_comm_mode_ctrl_test
   import hbc_pkg::*;
;
   localparam int PB = 32;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        token_here = 1'b0;
   logic        link_ready = 1'b0;
   logic [7:0]  tx_data;
   logic        tx_valid;
   logic        tx_last;
   logic        token_pass;
   logic        send_mode_bit;
   logic [31:1] rxm;
   logic [31:0] w;
   logic [15:0] r;
   int          failures = 0;
   int          check_count = 0;
   ////////////////////////////////////////////////////////////////////////
   hbc_if i_hbc_if ();
   hbc_host i_hbc_host (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
      .hp(i_hbc_if));
   hbc_device #(.PAGE_BYTES(PB)) i_hbc_device (.pclk(pclk), .presetn(presetn), .ce(1'b1), .hp(i_hbc_if),
      .token_here(token_here), .link_ready(link_ready), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_last(tx_last), .token_pass(token_pass), .send_mode_bit(send_mode_bit),
      .page_receive_mode_bits(rxm));
   hbc_props i_hbc_props (.pclk(pclk), .presetn(presetn), .bus_style_select(i_hbc_if.bus_style_select),
      .strobe_polarity_select(i_hbc_if.strobe_polarity_select), .wr_or_dir(i_hbc_if.wr_or_dir),
      .rd_or_ds(i_hbc_if.rd_or_ds), .host_doe(i_hbc_if.host_doe), .dev_doe(i_hbc_if.dev_doe),
      .token_here(token_here), .link_ready(link_ready), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_last(tx_last), .token_pass(token_pass));
   ////////////////////////////////////////////////////////////////////////
   always #12.5 pclk = ~pclk;
   // Far side stalls every other cycle
   always @(posedge pclk) link_ready <= ~link_ready;
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check

   task automatic give_verdict();
      $display("Checks made: %0d, mismatches: %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict

   task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      psel   <= 1'b1;
      pwrite <= wr_en;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // One device access through the controller, polled to completion
   task automatic dev(input logic wr_en, input logic [5:0] a, input logic [15:0] d, input logic [1:0] ln,
                      output logic [15:0] q);
      logic [31:0] s;
      int          n;
      n = 0;
      if (wr_en) apb(1'b1, P_WDATA, {16'h0000, d}, s);
      apb(1'b1, P_CMD, {21'h000000, ln, wr_en, 2'b00, a}, s);
      do begin
         apb(1'b0, P_STAT, 32'h00000000, s);
         n++;
      end while (s[0] !== 1'b0 && n < 60);
      if (n >= 60) failures++;
      q = s[31:16];
   endtask : dev

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      logic [15:0] q;
      dev(1'b1, a, d, 2'b01, q);
   endtask : wr

   task automatic rdc(input string name, input logic [5:0] a, input logic [1:0] ln, input logic [15:0] exp);
      logic [15:0] q;
      dev(1'b0, a, 16'h0000, ln, q);
      check(name, {16'h0000, q}, {16'h0000, exp});
   endtask : rdc

   // Hands the token over and collects what is sent
   task automatic token_rx(input logic [7:0] nexp, input logic pas);
      logic [7:0] got[$];
      logic       passed;
      passed = 1'b0;
      token_here <= 1'b1;
      @(posedge pclk);
      token_here <= 1'b0;
      repeat (16) begin
         @(posedge pclk);
         if (tx_valid === 1'b1 && link_ready === 1'b1) got.push_back(tx_data);
         if (token_pass === 1'b1) passed = 1'b1;
      end
      check("packet length", 32'(got.size()), {24'h000000, nexp});
      if (nexp != 8'h00) check("packet bytes", {16'h0000, got[0], got[1]}, 32'h00005AC3);
      if (pas) check("token passed", {31'h00000000, passed}, 32'h00000001);
   endtask : token_rx
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (40000) @(posedge pclk);
      failures++;
      give_verdict();
   end

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, P_CFG, 32'h00000000, w);
      check("config reset", w, {27'h0000000, CFG_RST});
      apb(1'b0, 8'h10, 32'h00000000, w);
      check("unmapped read", w, 32'h00000000);
      rdc("mode reset", A_MODE, 2'b01, {13'h0000, MODE_RST});
      check("send mode reset", {31'h00000000, send_mode_bit}, 32'h00000000);
      for (int i = 0; i < 16; i++) begin
         apb(1'b1, P_CFG, 32'(i), w);
         wr(A_PTR, 16'(16 + i));
         wr(A_DLO, 16'(160 + i));
         wr(A_PTR, 16'(16 + i));
         rdc("byte readback", A_DLO, 2'b01, 16'(160 + i));
         rdc("pointer step", A_PTR, 2'b01, 16'((17 + i) % PB));
      end
      apb(1'b1, P_CFG, 32'h00000010, w);
      wr(A_PTR, 16'h0004);
      wr(A_DLO, 16'hBEEF);
      wr(A_PTR, 16'h0004);
      rdc("word readback", A_DLO, 2'b01, 16'hBEEF);
      wr(A_PTR, 16'h0005);
      rdc("odd pointer word", A_DLO, 2'b01, 16'hBEEF);
      rdc("word pointer step", A_PTR, 2'b01, 16'h0006);
      apb(1'b1, P_CFG, 32'h00000011, w);
      dev(1'b1, A_PTR, 16'h0008, 2'b10, r);
      dev(1'b1, A_DLO, 16'h1234, 2'b10, r);
      dev(1'b1, A_PTR, 16'h0008, 2'b10, r);
      rdc("upper strobe word", A_DLO, 2'b10, 16'h1234);
      apb(1'b1, P_CFG, 32'h00000000, w);
      wr(A_PTR, 16'h0000);
      wr(A_DLO, 16'h0001);
      wr(A_DLO, 16'h0002);
      wr(A_DLO, 16'(PB - 2));
      wr(A_PTR, 16'(PB - 2));
      wr(A_DLO, 16'h005A);
      wr(A_DLO, 16'h00C3);
      wr(A_MODE, 16'h0000);
      token_rx(8'h00, 1'b0);
      wr(A_CMD, 16'h0001);
      token_rx(8'h02, 1'b1);
      token_rx(8'h00, 1'b0);
      wr(A_MODE, 16'h0001);
      check("send mode", {31'h00000000, send_mode_bit}, 32'h00000001);
      wr(A_CMD, 16'h0001);
      token_rx(8'h02, 1'b1);
      token_rx(8'h02, 1'b1);
      wr(A_MODE, 16'h0003);
      token_rx(8'h02, 1'b1);
      token_rx(8'h00, 1'b0);
      wr(A_CMD, 16'h0001);
      token_rx(8'h02, 1'b1);
      token_rx(8'h00, 1'b0);
      wr(A_MODE, 16'h0000);
      wr(A_PTR, 16'h0002);
      wr(A_DLO, 16'h0002);
      wr(A_CMD, 16'h0001);
      token_rx(8'h00, 1'b1);
      dev(1'b0, A_STAT, 16'h0000, 2'b01, r);
      check("error flags", {30'h00000000, r[STAT_PERR:STAT_TERR]}, 32'h00000003);
      wr(A_RXM, 16'h00FF);
      wr(A_RXM + 6'h03, 16'h0080);
      check("receive modes", {1'b0, rxm}, {1'b0, 1'b1, 23'h000000, 7'h7F});
      wr(A_MODE, 16'h0004);
      wr(A_PTR, 16'h000A);
      wr(A_DLO, 16'h0034);
      wr(A_DHI, 16'h0012);
      wr(A_PTR, 16'h000A);
      rdc("word mode low", A_DLO, 2'b01, 16'h0034);
      rdc("word mode high", A_DHI, 2'b01, 16'h0012);
      rdc("word mode step", A_PTR, 2'b01, 16'h000C);
      give_verdict();
   end
endmodule : host_bus_and_comm_mode_ctrl_test
`default_nettype wire
